// file: hw/iopm_mux.sv
// Pin function multiplexer top: twelve pin control registers on APB and one
// pin cell per pin between the peripherals and the pads.
// Assumes APB3 master on mclk_in; pad inputs synchronous to mclk_in.
`timescale 1ns/1ps
`default_nettype none
module iopm_mux (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [191:0] periph_dout_in,
    input wire logic [191:0] periph_doe_in,
    output logic [191:0] periph_din_out,
    input wire logic [11:0] pad_in_in,
    output logic [11:0] pad_out_out,
    output logic [11:0] pad_oe_n_out,
    output logic [11:0] pad_pullup_out,
    output logic [11:0] pad_pulldown_out,
    output logic [11:0] pad_hyst_out,
    output logic [11:0] analog_sel_out,
    output logic deepest_sleep_state_wake_out,
    output logic lowpower_wake_out
);
    // =====================================================================
    // address decode
    function automatic logic [3:0] iopm_decode(input logic [31:0] addr);
        logic [3:0] idx;
        idx = iopm_pkg::IOPM_IDX_NONE;
        for (int k = 0; k < iopm_pkg::IOPM_PINS; k++) begin
            if (addr == iopm_pkg::IOPM_PIN_ADDR[k]) begin
                idx = 4'(k);
            end
        end
        return idx;
    endfunction

    wire [3:0] addr_idx = iopm_decode(paddr_in);
    wire addr_hit = (addr_idx != iopm_pkg::IOPM_IDX_NONE);
    wire access = psel_in & penable_in;
    wire fire = access & pready_out;
    wire wr_fire = fire & pwrite_in & addr_hit;
    wire next_pready = access & ~pready_out;
    wire rd_load = next_pready & ~pwrite_in;
    wire next_pslverr = next_pready & ~addr_hit;

    // =====================================================================
    // pin control registers and pin cells
    logic [31:0] cfg [iopm_pkg::IOPM_PINS];
    wire [31:0] rd_word [iopm_pkg::IOPM_PINS];
    wire [11:0] cell_shut;
    wire [11:0] cell_lp;

    genvar gi;
    generate
        for (gi = 0; gi < iopm_pkg::IOPM_PINS; gi++) begin : g_pin
            localparam logic [31:0] WMASK = iopm_pkg::iopm_wmask(iopm_pkg::IOPM_PIN_BUF[gi]);
            wire sel_wr = wr_fire && (addr_idx == 4'(gi));

            // only settings the buffer has can be stored
            always_ff @(posedge mclk_in) begin
                if (sys_rst_in) begin
                    cfg[gi] <= iopm_pkg::IOPM_CFG_RST;
                end else if (sel_wr) begin
                    cfg[gi] <= pwdata_in & WMASK;
                end
            end

            // live pad level and wake request read back beside the settings
            assign rd_word[gi] = cfg[gi]
                | ({31'h0000_0000, pad_in_in[gi]} << iopm_pkg::IOPM_LVL_BIT)
                | ({31'h0000_0000, cell_shut[gi] | cell_lp[gi]} << iopm_pkg::IOPM_WKREQ_BIT);

            iopm_pin_cell #(
                .FUNC_MASK(iopm_pkg::IOPM_FUNC_MASK[gi]),
                .BUF(iopm_pkg::IOPM_PIN_BUF[gi])
            ) u_cell (
                .mclk_in(mclk_in),
                .sys_rst_in(sys_rst_in),
                .cfg_in(cfg[gi]),
                .pad_in_in(pad_in_in[gi]),
                .dout_in(periph_dout_in[gi*16 +: 16]),
                .doe_in(periph_doe_in[gi*16 +: 16]),
                .din_out(periph_din_out[gi*16 +: 16]),
                .pad_out_out(pad_out_out[gi]),
                .pad_oe_n_out(pad_oe_n_out[gi]),
                .pullup_out(pad_pullup_out[gi]),
                .pulldown_out(pad_pulldown_out[gi]),
                .hyst_out(pad_hyst_out[gi]),
                .analog_out(analog_sel_out[gi]),
                .shut_wake_out(cell_shut[gi]),
                .lp_wake_out(cell_lp[gi])
            );

            // one connected function at most
            one_func_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
                $onehot0(periph_din_out[gi*16 +: 16]))
                else $error("more than one function connected on a pin");
        end
    endgenerate

    wire [31:0] next_prdata = (rd_load && addr_hit) ? rd_word[addr_idx]
                                                    : iopm_pkg::IOPM_RD_NONE;
    wire next_shut = |cell_shut;
    wire next_lp = |cell_lp;

    // =====================================================================
    // bus answer and wake outputs
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= iopm_pkg::IOPM_RD_NONE;
            deepest_sleep_state_wake_out <= 1'b0;
            lowpower_wake_out <= 1'b0;
        end else begin
            pready_out <= next_pready;
            pslverr_out <= next_pslverr;
            prdata_out <= next_prdata;
            deepest_sleep_state_wake_out <= next_shut;
            lowpower_wake_out <= next_lp;
        end
    end

    // =====================================================================
    // checks
    wire [3:0] pf0 = cfg[0][iopm_pkg::IOPM_PF_MSB:iopm_pkg::IOPM_PF_LSB];
    wire [3:0] pf3 = cfg[3][iopm_pkg::IOPM_PF_MSB:iopm_pkg::IOPM_PF_LSB];
    wire inv0 = cfg[0][iopm_pkg::IOPM_INV_BIT];
    wire inv3 = cfg[3][iopm_pkg::IOPM_INV_BIT];
    wire inv5 = cfg[5][iopm_pkg::IOPM_INV_BIT];

    ready_pulse_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        pready_out |=> !pready_out)
        else $error("pready held for more than one cycle");

    ready_time_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (psel_in && !penable_in) ##1 (psel_in && penable_in) |=> pready_out)
        else $error("pready not one cycle into the access phase");

    cfg_write_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (wr_fire && addr_idx == 4'h3) |=>
            pf3 == $past(pwdata_in[iopm_pkg::IOPM_PF_MSB:iopm_pkg::IOPM_PF_LSB]))
        else $error("function select not stored on write");

    analog_keep_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        analog_sel_out[3] == $past(cfg[3][iopm_pkg::IOPM_ANA_BIT]))
        else $error("analog enable not following its register bit");

    std_nowake_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !cfg[2][iopm_pkg::IOPM_WAKE_BIT] && !pad_hyst_out[2] && !cell_shut[2])
        else $error("plain standard pin shows wake or hysteresis");

    od_nopull_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        pad_pullup_out[1:0] == 2'b00 && (pad_oe_n_out[0] || !pad_out_out[0]))
        else $error("open drain pin pulls up or drives high");

    shut_wake_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (cfg[0][iopm_pkg::IOPM_WAKE_BIT] && (pad_in_in[0] ^ inv0)) |-> ##2 deepest_sleep_state_wake_out)
        else $error("deep sleep wake not raised two cycles after pin event");

    lp_wake_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (cfg[5][iopm_pkg::IOPM_FWAKE_BIT] && (pad_in_in[5] ^ inv5)) |-> ##2 lowpower_wake_out)
        else $error("low power wake not raised two cycles after pin event");

    gpio_sel_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (pf3 == iopm_pkg::IOPM_PF_GPIO && cfg[3][iopm_pkg::IOPM_PC_BIT]) |=>
            periph_din_out[3*16+1] == $past(pad_in_in[3] ^ inv3))
        else $error("port bit not connected on code one");

    unassigned_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (!iopm_pkg::IOPM_FUNC_MASK[0][pf0]) |=>
            periph_din_out[15:0] == 16'h0000 && pad_oe_n_out[0])
        else $error("unassigned code left a function connected");

    err_unmapped_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (access && !pready_out && !addr_hit) |=> pready_out && pslverr_out)
        else $error("unmapped access not answered with error");
endmodule
`default_nettype wire

// file: common/iopm_pkg.sv
// Constants for the per-pin function multiplexer: register map, field layout,
// per-pin function availability and buffer kinds.
// Assumes a 32-bit APB register bus and twelve managed port A pins.
package iopm_pkg;

    // =====================================================================
    // sizes
    localparam int IOPM_PINS = 12;
    localparam int IOPM_FUNCS = 16;
    localparam int IOPM_PF_W = 4;
    localparam int IOPM_IDX_W = 4;
    localparam logic [3:0] IOPM_IDX_NONE = 4'hF;

    // =====================================================================
    // register byte addresses, one per pin
    localparam logic [31:0] IOPM_PIN_ADDR [IOPM_PINS] = '{
        32'h4042_8000, 32'h4042_8004, 32'h4042_8010, 32'h4042_8014,
        32'h4042_8018, 32'h4042_801C, 32'h4042_8020, 32'h4042_8024,
        32'h4042_8030, 32'h4042_8034, 32'h4042_8038, 32'h4042_803C};

    // =====================================================================
    // field layout of a pin control register
    localparam int IOPM_PF_LSB = 0;
    localparam int IOPM_PF_MSB = 3;
    localparam int IOPM_PC_BIT = 7;
    localparam int IOPM_PD_BIT = 16;
    localparam int IOPM_PU_BIT = 17;
    localparam int IOPM_HYS_BIT = 25;
    localparam int IOPM_INV_BIT = 26;
    localparam int IOPM_WAKE_BIT = 27;
    localparam int IOPM_FWAKE_BIT = 28;
    localparam int IOPM_ANA_BIT = 29;
    localparam int IOPM_WKREQ_BIT = 30;
    localparam int IOPM_LVL_BIT = 31;

    localparam logic [31:0] IOPM_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] IOPM_RD_NONE = 32'h0000_0000;
    localparam logic [3:0] IOPM_PF_NONE = 4'h0;
    localparam logic [3:0] IOPM_PF_GPIO = 4'h1;

    // writable bits: the base common to every buffer kind, then the per-kind additions
    localparam logic [31:0] IOPM_WM_BASE = 32'h3400_008F;
    localparam logic [31:0] IOPM_WM_PULLS = 32'h0003_0000;
    localparam logic [31:0] IOPM_WM_WAKE = 32'h0800_0000;
    localparam logic [31:0] IOPM_WM_HYS = 32'h0200_0000;
    localparam logic [31:0] IOPM_WM_PD = 32'h0001_0000;

    // =====================================================================
    // buffer kinds and per-pin tables
    typedef enum {
        IOPM_BUF_SDIO,
        IOPM_BUF_SDIO_WAKE,
        IOPM_BUF_OPEN_DRAIN_TOLERANT_BUFFER
    } iopm_buf_t;

    localparam iopm_buf_t IOPM_PIN_BUF [IOPM_PINS] = '{
        IOPM_BUF_OPEN_DRAIN_TOLERANT_BUFFER, IOPM_BUF_OPEN_DRAIN_TOLERANT_BUFFER, IOPM_BUF_SDIO, IOPM_BUF_SDIO,
        IOPM_BUF_SDIO, IOPM_BUF_SDIO, IOPM_BUF_SDIO, IOPM_BUF_SDIO,
        IOPM_BUF_SDIO, IOPM_BUF_SDIO, IOPM_BUF_SDIO_WAKE, IOPM_BUF_SDIO_WAKE};

    // bit n set: a peripheral is assigned to function code n on that pin
    localparam logic [15:0] IOPM_FUNC_MASK [IOPM_PINS] = '{
        16'h17FE, 16'h7EFE, 16'h1BFE, 16'h5FBE,
        16'h3FFE, 16'h1BFE, 16'h7FFE, 16'h7FFE,
        16'h7FFE, 16'h3FFE, 16'h7DFE, 16'h55FE};

    // settings that the buffer kind really has
    function automatic logic [31:0] iopm_wmask(input iopm_buf_t kind);
        logic [31:0] m;
        m = IOPM_WM_BASE;
        case (kind)
            IOPM_BUF_SDIO: m = m | IOPM_WM_PULLS;
            IOPM_BUF_SDIO_WAKE: m = m | IOPM_WM_PULLS | IOPM_WM_WAKE;
            default: m = m | IOPM_WM_HYS | IOPM_WM_PD | IOPM_WM_WAKE;
        endcase
        return m;
    endfunction

endpackage

// file: hw/iopm_pin_cell.sv
// One pin of the function multiplexer: selects one peripheral by code,
// conditions the pad input, drives the pad and raises wake requests.
// Assumes cfg_in comes already masked to the settings the buffer has.
`timescale 1ns/1ps
`default_nettype none
module iopm_pin_cell #(
    parameter logic [15:0] FUNC_MASK = 16'h0000,
    parameter iopm_pkg::iopm_buf_t BUF = iopm_pkg::IOPM_BUF_SDIO
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic [31:0] cfg_in,
    input wire logic pad_in_in,
    input wire logic [15:0] dout_in,
    input wire logic [15:0] doe_in,
    output logic [15:0] din_out,
    output logic pad_out_out,
    output logic pad_oe_n_out,
    output logic pullup_out,
    output logic pulldown_out,
    output logic hyst_out,
    output logic analog_out,
    output logic shut_wake_out,
    output logic lp_wake_out
);
    // =====================================================================
    // field decode
    wire [3:0] pf = cfg_in[iopm_pkg::IOPM_PF_MSB:iopm_pkg::IOPM_PF_LSB];
    wire inv = cfg_in[iopm_pkg::IOPM_INV_BIT];
    wire pc = cfg_in[iopm_pkg::IOPM_PC_BIT];
    wire func_ok = FUNC_MASK[pf] && (pf != iopm_pkg::IOPM_PF_NONE);
    wire in_lvl = pad_in_in ^ inv;
    wire drv_val = dout_in[pf] ^ inv;
    wire drv_en = func_ok & doe_in[pf];
    wire [15:0] one_hot = 16'h0001 << pf;
    wire [15:0] next_din = (func_ok && pc) ? (one_hot & {16{in_lvl}}) : 16'h0000;
    wire next_out;
    wire next_oe_n;

    // =====================================================================
    // output stage per buffer kind
    generate
        if (BUF == iopm_pkg::IOPM_BUF_OPEN_DRAIN_TOLERANT_BUFFER) begin : g_od
            // open drain: only ever pulls low
            assign next_out = 1'b0;
            assign next_oe_n = ~(drv_en & ~drv_val);
        end else begin : g_pp
            assign next_out = drv_val & drv_en;
            assign next_oe_n = ~drv_en;
        end
    endgenerate

    // wake paths bypass the selector and coexist with it
    wire next_shut = cfg_in[iopm_pkg::IOPM_WAKE_BIT] & in_lvl;
    wire next_lp = cfg_in[iopm_pkg::IOPM_FWAKE_BIT] & in_lvl;

    // =====================================================================
    // registered outputs
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            din_out <= 16'h0000;
            pad_out_out <= 1'b0;
            pad_oe_n_out <= 1'b1;
            pullup_out <= 1'b0;
            pulldown_out <= 1'b0;
            hyst_out <= 1'b0;
            analog_out <= 1'b0;
            shut_wake_out <= 1'b0;
            lp_wake_out <= 1'b0;
        end else begin
            din_out <= next_din;
            pad_out_out <= next_out;
            pad_oe_n_out <= next_oe_n;
            pullup_out <= cfg_in[iopm_pkg::IOPM_PU_BIT];
            pulldown_out <= cfg_in[iopm_pkg::IOPM_PD_BIT];
            hyst_out <= cfg_in[iopm_pkg::IOPM_HYS_BIT];
            analog_out <= cfg_in[iopm_pkg::IOPM_ANA_BIT];
            shut_wake_out <= next_shut;
            lp_wake_out <= next_lp;
        end
    end
endmodule
`default_nettype wire

// file: tb/iopm_board_model.sv
// Board side of the twelve pads: pulls, an external driver and float noise.
// Assumes pad outputs of the mux are registers on mclk_in.
`timescale 1ns/1ps
`default_nettype none
module iopm_board_model (
    input wire logic mclk_in,
    input wire logic [11:0] pad_out_in,
    input wire logic [11:0] pad_oe_n_in,
    input wire logic [11:0] pullup_in,
    input wire logic [11:0] pulldown_in,
    input wire logic [11:0] ext_en_in,
    input wire logic [11:0] ext_val_in,
    output logic [11:0] pad_level_out
);
    // =====================================================================
    // floating pads toggle so a stale level never passes
    logic [11:0] float_pat = 12'hA5A;
    always @(posedge mclk_in) begin
        float_pat <= ~float_pat;
    end
    // =====================================================================
    // pad level
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            if (!pad_oe_n_in[i]) begin
                pad_level_out[i] = pad_out_in[i];
            end else if (ext_en_in[i]) begin
                pad_level_out[i] = ext_val_in[i];
            end else if (pullup_in[i]) begin
                pad_level_out[i] = 1'b1;
            end else if (pulldown_in[i]) begin
                pad_level_out[i] = 1'b0;
            end else begin
                pad_level_out[i] = float_pat[i];
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/tb_iopm_mux.sv
// Self-checking bench of the pin function mux: APB master, peripherals, board.
// Assumes one 125 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module tb_iopm_mux;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sd_wake, lp_wake;
    logic [191:0] dout = '0;
    logic [191:0] doe = '0;
    logic [191:0] din;
    logic [11:0] pad_lvl, pad_out, pad_oe_n, pu, pd, hys, ana;
    logic [11:0] ext_en = 12'hFFF;
    logic [11:0] ext_val = 12'h000;
    int bad_count = 0;
    int num_checks = 0;

    iopm_mux u_iopm_mux (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .periph_dout_in(dout), .periph_doe_in(doe), .periph_din_out(din),
        .pad_in_in(pad_lvl), .pad_out_out(pad_out), .pad_oe_n_out(pad_oe_n),
        .pad_pullup_out(pu), .pad_pulldown_out(pd), .pad_hyst_out(hys),
        .analog_sel_out(ana), .deepest_sleep_state_wake_out(sd_wake), .lowpower_wake_out(lp_wake));
    iopm_board_model u_iopm_board_model (.mclk_in(mclk_in), .pad_out_in(pad_out),
        .pad_oe_n_in(pad_oe_n), .pullup_in(pu), .pulldown_in(pd), .ext_en_in(ext_en),
        .ext_val_in(ext_val), .pad_level_out(pad_lvl));

    initial begin
        forever #4 mclk_in = ~mclk_in;
    end

    // =====================================================================
    // reporting and bus tasks
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        int n;
        @(posedge mclk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        // sampled at the rising edge, before the slave's registers update
        for (n = 0; n < 20; n++) begin
            @(posedge mclk_in);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            bad_count++;
            $display("[ERR] %0t no ready", $time);
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] wr_mask(input int i);
        case (iopm_pkg::IOPM_PIN_BUF[i])
            iopm_pkg::IOPM_BUF_SDIO: return 32'h3403008F;
            iopm_pkg::IOPM_BUF_SDIO_WAKE: return 32'h3C03008F;
            default: return 32'h3E01008F;
        endcase
    endfunction

    // =====================================================================
    // main sequence
    initial begin
        logic [31:0] rd, a, m;
        logic err, inv, pc, ok, v, drv, lvl, open_drain_tolerant_buffer;
        logic [3:0] f;
        int i;
        void'($urandom(32'h8619AC17));
        repeat (16) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        @(negedge mclk_in);
        check(32'(pad_oe_n), 32'h00000FFF);
        for (i = 0; i < 12; i++) begin
            a = iopm_pkg::IOPM_PIN_ADDR[i];
            apb(1'b0, a, 32'h0, rd, err);
            check(rd, 32'h0);
            apb(1'b1, a, 32'hFFFFFFFF, rd, err);
            apb(1'b0, a, 32'h0, rd, err);
            m = wr_mask(i);
            check(rd & 32'h3FFFFFFF, m);
            check(32'({pu[i], pd[i], hys[i]}), m[17] ? 32'h6 : 32'h3);
            apb(1'b1, a, 32'h0, rd, err);
        end
        apb(1'b0, 32'h40428008, 32'h0, rd, err);
        check(32'(err), 32'h1);
        check(rd, 32'h0);
        // random selects, first sixteen sweep every code
        for (int k = 0; k < 240; k++) begin
            i = k < 16 ? k % 12 : $urandom_range(11);
            f = k < 16 ? 4'(k) : 4'($urandom_range(15));
            inv = 1'($urandom);
            pc = 1'($urandom);
            @(posedge mclk_in);
            dout[i*16 +: 16] <= 16'($urandom);
            doe[i*16 +: 16] <= 16'($urandom);
            ext_val[i] <= 1'($urandom);
            apb(1'b1, iopm_pkg::IOPM_PIN_ADDR[i], {5'h0, inv, 18'h0, pc, 3'h0, f}, rd, err);
            repeat (5) @(negedge mclk_in);
            open_drain_tolerant_buffer = iopm_pkg::IOPM_PIN_BUF[i] == iopm_pkg::IOPM_BUF_OPEN_DRAIN_TOLERANT_BUFFER;
            ok = f != 4'h0 && iopm_pkg::IOPM_FUNC_MASK[i][f];
            v = dout[i*16+f] ^ inv;
            drv = ok && doe[i*16+f] && !(open_drain_tolerant_buffer && v);
            check(32'(pad_oe_n[i]), 32'(!drv));
            if (drv) check(32'(pad_out[i]), 32'(v));
            lvl = drv ? v : ext_val[i];
            check(32'(din[i*16 +: 16]), ok && pc ? 32'(16'(lvl ^ inv) << f) : 32'h0);
        end
        // analog and wake, alone and beside a digital function
        for (i = 0; i < 12; i++) begin
            for (int j = 0; j < 2; j++) begin
                a = iopm_pkg::IOPM_PIN_ADDR[i];
                @(posedge mclk_in);
                doe[i*16 +: 16] <= 16'h0;
                ext_val[i] <= 1'b1;
                apb(1'b1, a, j ? 32'h38000081 : 32'h38000000, rd, err);
                repeat (5) @(negedge mclk_in);
                check(32'(ana[i]), 32'h1);
                check(32'(lp_wake), 32'h1);
                check(32'(sd_wake), 32'(iopm_pkg::IOPM_PIN_BUF[i] != iopm_pkg::IOPM_BUF_SDIO));
                @(posedge mclk_in);
                ext_val[i] <= 1'b0;
                repeat (5) @(negedge mclk_in);
                check(32'({sd_wake, lp_wake}), 32'h0);
                apb(1'b1, a, 32'h0, rd, err);
            end
        end
        print_verdict();
    end
endmodule
`default_nettype wire
